//--- rtl/sleep_wake_cfg.svh
// Purpose: constants for the reset-cause and sleep/wake controller
// Assumes: 100 MHz sys_clk
// Notes:   times in their own units, cycle counts derived from them
`ifndef SLEEP_WAKE_CFG_SVH
`define SLEEP_WAKE_CFG_SVH

`define CLK_MHZ            100
`define HOLD_US_POR        18000
`define HOLD_US_SUB        300
`define HOLD_CYC_POR       (`HOLD_US_POR * `CLK_MHZ)
`define HOLD_CYC_SUB       (`HOLD_US_SUB * `CLK_MHZ)
`define HOLD_W             21
`define WDT_W              16
`define WDT_LIMIT_DEF      16'hffff
`define STAT_TO_BIT        4
`define STAT_PD_BIT        3
`define STAT_WAKE_BIT      7
`define CMD_W              6
`define DATA_W             14
`define ADDR_W             10
`define OPEN_LOCS          10'h040
`define LAST_LOC           10'h3ff
`define ID_NUM             4
`define ID_BASE            10'h400
`define ID_LOW_MASK        14'h000f
`define CMD_LOAD           6'h02
`define CMD_READ           6'h04
`define CMD_INC            6'h06
`define CMD_LOAD_ID        6'h00

`endif

//--- rtl/sleep_wake_pkg.sv
// Purpose: types shared by the sleep/wake controller
// Assumes: nothing
// Notes:   constants live in sleep_wake_cfg.svh
`default_nettype none
package sleep_wake_pkg;
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_RUN,
		ST_SLEEP,
		ST_PROG
	} pwr_state_t;
	typedef enum logic [1:0] {
		SH_CMD,
		SH_DIN,
		SH_DOUT
	} ser_state_t;
endpackage
`default_nettype wire

//--- rtl/serial_prog.sv
// Purpose: serial program/verify shifter with read-out gating and id words
// Assumes: clock and data already synchronised; lsb first
// Notes:   memory itself is outside; this block gates, shifts and keeps the id words
`include "sleep_wake_cfg.svh"
`default_nettype none
module serial_prog (
	input  wire logic                 sys_clk,
	input  wire logic                 arst_n,
	input  wire logic                 active,
	input  wire logic                 sclk,
	input  wire logic                 sdata,
	input  wire logic                 code_protect,
	input  wire logic [`DATA_W-1:0]   mem_rdata,
	output logic      [`ADDR_W-1:0]   mem_addr,
	output logic      [`DATA_W-1:0]   mem_wdata,
	output logic                      mem_we,
	output logic                      sdata_out,
	output logic                      sdata_oe
);
	logic [`CMD_W-1:0]   cmd_reg;
	logic [`DATA_W-1:0]  sh_reg;
	logic [4:0]          cnt_reg;
	logic                clk_d_reg;
	logic                id_sel_reg;
	logic [`DATA_W-1:0]  id_mem [`ID_NUM];
	sleep_wake_pkg::ser_state_t st_reg;
	logic                rise;

	function automatic logic readable(input logic [`ADDR_W-1:0] a,
		input logic prot);
		readable = !prot || a < `OPEN_LOCS || a == `LAST_LOC;
	endfunction

	assign rise = sclk && !clk_d_reg;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			clk_d_reg <= 1'b0;
		else
			clk_d_reg <= sclk;
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg     <= sleep_wake_pkg::SH_CMD;
			cmd_reg    <= '0;
			sh_reg     <= '0;
			cnt_reg    <= '0;
			mem_addr   <= '0;
			mem_wdata  <= '0;
			mem_we     <= 1'b0;
			sdata_out  <= 1'b0;
			sdata_oe   <= 1'b0;
			id_sel_reg <= 1'b0;
			for (int i = 0; i < `ID_NUM; i++)
				id_mem[i] <= '0;
		end else if (!active) begin
			st_reg   <= sleep_wake_pkg::SH_CMD;
			cnt_reg  <= '0;
			mem_we   <= 1'b0;
			sdata_oe <= 1'b0;
		end else begin
			mem_we <= 1'b0;
			if (rise) begin
				case (st_reg)
				sleep_wake_pkg::SH_CMD: begin
					cmd_reg <= {sdata, cmd_reg[`CMD_W-1:1]};
					cnt_reg <= cnt_reg + 5'd1;
					if (cnt_reg == 5'(`CMD_W - 1)) begin
						cnt_reg <= '0;
						case ({sdata, cmd_reg[`CMD_W-1:1]})
						`CMD_LOAD, `CMD_LOAD_ID:
							st_reg <= sleep_wake_pkg::SH_DIN;
						`CMD_READ: begin
							st_reg <= sleep_wake_pkg::SH_DOUT;
							if (id_sel_reg)
								sh_reg <= id_mem[mem_addr[1:0]];
							else if (readable(mem_addr, code_protect))
								sh_reg <= mem_rdata;
							else
								sh_reg <= '0;
						end
						`CMD_INC:
							if (id_sel_reg)
								mem_addr <= mem_addr + 10'd1;
							else
								mem_addr <= mem_addr + 10'd1;
						default: ;
						endcase
						if ({sdata, cmd_reg[`CMD_W-1:1]} == `CMD_LOAD_ID)
							id_sel_reg <= 1'b1;
					end
				end
				sleep_wake_pkg::SH_DIN: begin
					sh_reg  <= {sdata, sh_reg[`DATA_W-1:1]};
					cnt_reg <= cnt_reg + 5'd1;
					if (cnt_reg == 5'(`DATA_W - 1)) begin
						cnt_reg <= '0;
						st_reg  <= sleep_wake_pkg::SH_CMD;
						if (id_sel_reg)
							id_mem[mem_addr[1:0]] <=
								{sdata, sh_reg[`DATA_W-1:1]}
								& `ID_LOW_MASK;
						else begin
							mem_wdata <= {sdata, sh_reg[`DATA_W-1:1]};
							mem_we    <= 1'b1;
						end
					end
				end
				sleep_wake_pkg::SH_DOUT: begin
					sdata_oe  <= 1'b1;
					sdata_out <= sh_reg[0];
					sh_reg    <= {1'b0, sh_reg[`DATA_W-1:1]};
					cnt_reg   <= cnt_reg + 5'd1;
					if (cnt_reg == 5'(`DATA_W)) begin
						cnt_reg  <= '0;
						sdata_oe <= 1'b0;
						st_reg   <= sleep_wake_pkg::SH_CMD;
					end
				end
				default: st_reg <= sleep_wake_pkg::SH_CMD;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- rtl/sleep_wake.sv
// Purpose: reset-cause flags, power-down entry and wake-up for a small mcu
// Assumes: halt_op and port_op are one-cycle strobes from the core
// Notes:   sys_clk models the always-on rc clock; core_clk_en gates the core
`include "sleep_wake_cfg.svh"
`default_nettype none
module sleep_wake #(
	parameter logic [`HOLD_W-1:0] HOLD_POR = `HOLD_W'(`HOLD_CYC_POR),
	parameter logic [`HOLD_W-1:0] HOLD_SUB = `HOLD_W'(`HOLD_CYC_SUB),
	parameter logic [`WDT_W-1:0]  WDT_LIMIT = `WDT_LIMIT_DEF
) (
	input  wire logic                sys_clk,
	input  wire logic                arst_n,
	input  wire logic                ext_reset_n,
	input  wire logic                vpp_high,
	input  wire logic                port_pin0,
	input  wire logic                port_pin1,
	input  wire logic                port_pin3,
	input  wire logic                port_pin4,
	input  wire logic                halt_op,
	input  wire logic                wdt_clear_op,
	input  wire logic                port_op,
	input  wire logic                wdt_enable,
	input  wire logic                reset_pin_is_ext_reset_n,
	input  wire logic                wake_on_change_en,
	input  wire logic                slow_osc_cfg,
	input  wire logic                code_protect,
	input  wire logic [5:0]          pin_drive_in,
	input  wire logic [5:0]          pin_oe_in,
	input  wire logic [`DATA_W-1:0]  mem_rdata,
	output logic                     core_reset,
	output logic                     core_clk_en,
	output logic                     osc_drive_en,
	output logic                     timeout_flag_n,
	output logic                     powerdown_flag_n,
	output logic                     pin_wake_flag,
	output logic                     prog_mode,
	output logic [5:0]               pin_drive_out,
	output logic [5:0]               pin_oe_out,
	output logic [`ADDR_W-1:0]       mem_addr,
	output logic [`DATA_W-1:0]       mem_wdata,
	output logic                     mem_we,
	output logic                     sdata_out,
	output logic                     sdata_oe
);
	// two-flop synchronisers for all pin inputs
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	logic [6:0] pin_raw;
	assign pin_raw = {vpp_high, ext_reset_n, port_pin4, port_pin3,
		port_pin1, port_pin0, 1'b0};

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= 7'h20;
			sync2_reg <= 7'h20;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
		end
	end

	logic       vpp_s;
	logic       ext_reset_n_n_s;
	logic [3:0] wpins_s;
	assign vpp_s    = sync2_reg[6];
	assign ext_reset_n_n_s = sync2_reg[5];
	assign wpins_s  = sync2_reg[4:1];

	sleep_wake_pkg::pwr_state_t st_reg;
	logic [`HOLD_W-1:0] hold_reg;
	logic [`WDT_W-1:0]  wdt_reg;
	logic [3:0]         snap_reg;
	logic               ext_reset_n_n_d_reg;
	logic               ext_reset_n_fall;
	logic               ext_reset_n_active;
	logic               wdt_expire;
	logic               pin_change;
	logic               prog_entry;
	logic               asleep;

	assign asleep      = (st_reg == sleep_wake_pkg::ST_SLEEP);
	assign ext_reset_n_active = reset_pin_is_ext_reset_n && !ext_reset_n_n_s;
	assign ext_reset_n_fall   = reset_pin_is_ext_reset_n && ext_reset_n_n_d_reg && !ext_reset_n_n_s;
	assign wdt_expire  = wdt_enable && (wdt_reg == WDT_LIMIT);
	assign pin_change  = asleep && wake_on_change_en
		&& (wpins_s != snap_reg);
	assign prog_entry  = vpp_s && !wpins_s[1] && !wpins_s[0];

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			ext_reset_n_n_d_reg <= 1'b1;
		else
			ext_reset_n_n_d_reg <= ext_reset_n_n_s;
	end

	// snapshot taken on every port file/bit operation while running
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			snap_reg <= '0;
		else if (port_op && st_reg == sleep_wake_pkg::ST_RUN)
			snap_reg <= wpins_s;
	end

	// watchdog: runs from the always-on clock, also during sleep
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			wdt_reg <= '0;
		else if (!wdt_enable || wdt_expire || halt_op || wdt_clear_op
			|| st_reg == sleep_wake_pkg::ST_HOLD)
			wdt_reg <= '0;
		else
			wdt_reg <= wdt_reg + `WDT_W'(1);
	end

	// power state and hold timer; every wake goes back through hold
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg   <= sleep_wake_pkg::ST_HOLD;
			hold_reg <= HOLD_POR;
		end else begin
			case (st_reg)
			sleep_wake_pkg::ST_HOLD: begin
				if (prog_entry)
					st_reg <= sleep_wake_pkg::ST_PROG;
				else if (ext_reset_n_active)
					hold_reg <= hold_reg; // timer waits for pin release
				else if (hold_reg <= `HOLD_W'(1))
					st_reg <= sleep_wake_pkg::ST_RUN;
				else
					hold_reg <= hold_reg - `HOLD_W'(1);
			end
			sleep_wake_pkg::ST_RUN: begin
				if (prog_entry)
					st_reg <= sleep_wake_pkg::ST_PROG;
				else if (ext_reset_n_fall || wdt_expire) begin
					st_reg   <= sleep_wake_pkg::ST_HOLD;
					hold_reg <= slow_osc_cfg ? HOLD_POR : HOLD_SUB;
				end else if (halt_op)
					st_reg <= sleep_wake_pkg::ST_SLEEP;
			end
			sleep_wake_pkg::ST_SLEEP: begin
				// only an enabled event leaves sleep
				if (ext_reset_n_fall || wdt_expire || pin_change) begin
					st_reg   <= sleep_wake_pkg::ST_HOLD;
					hold_reg <= slow_osc_cfg ? HOLD_POR : HOLD_SUB;
				end
			end
			sleep_wake_pkg::ST_PROG: begin
				if (!vpp_s) begin
					st_reg   <= sleep_wake_pkg::ST_HOLD;
					hold_reg <= HOLD_POR;
				end
			end
			default: st_reg <= sleep_wake_pkg::ST_HOLD;
			endcase
		end
	end

	// status flags: only reset events or halt touch them
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			timeout_flag_n   <= 1'b1;
			powerdown_flag_n <= 1'b1;
			pin_wake_flag    <= 1'b0;
		end else if (st_reg == sleep_wake_pkg::ST_RUN) begin
			if (ext_reset_n_fall)
				pin_wake_flag <= 1'b0;
			else if (wdt_expire) begin
				pin_wake_flag  <= 1'b0;
				timeout_flag_n <= 1'b0;
			end else if (halt_op) begin
				timeout_flag_n   <= 1'b1;
				powerdown_flag_n <= 1'b0;
			end
		end else if (asleep) begin
			if (ext_reset_n_fall) begin
				pin_wake_flag  <= 1'b0;
				timeout_flag_n <= 1'b1;
			end else if (wdt_expire) begin
				pin_wake_flag  <= 1'b0;
				timeout_flag_n <= 1'b0;
			end else if (pin_change) begin
				pin_wake_flag  <= 1'b1;
				timeout_flag_n <= 1'b1;
			end
		end
	end

	// core control; watchdog reset works internally, no pin drive
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			core_reset   <= 1'b1;
			core_clk_en  <= 1'b0;
			osc_drive_en <= 1'b1;
			prog_mode    <= 1'b0;
		end else begin
			core_reset   <= (st_reg != sleep_wake_pkg::ST_RUN)
				&& !asleep;
			core_clk_en  <= (st_reg == sleep_wake_pkg::ST_RUN)
				&& !halt_op;
			osc_drive_en <= !asleep && !(st_reg ==
				sleep_wake_pkg::ST_RUN && halt_op);
			prog_mode    <= (st_reg == sleep_wake_pkg::ST_PROG);
		end
	end

	// pin drive frozen while asleep
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_drive_out <= '0;
			pin_oe_out    <= '0;
		end else if (!asleep) begin
			pin_drive_out <= pin_drive_in;
			pin_oe_out    <= pin_oe_in;
		end
	end

	// program/verify port: pin 1 clock, pin 0 data (already schmitt)
	serial_prog u_prog (
		.sys_clk      (sys_clk),
		.arst_n       (arst_n),
		.active       (st_reg == sleep_wake_pkg::ST_PROG),
		.sclk         (wpins_s[1]),
		.sdata        (wpins_s[0]),
		.code_protect (code_protect),
		.mem_rdata    (mem_rdata),
		.mem_addr     (mem_addr),
		.mem_wdata    (mem_wdata),
		.mem_we       (mem_we),
		.sdata_out    (sdata_out),
		.sdata_oe     (sdata_oe)
	);
endmodule
`default_nettype wire

//--- test/sleep_wake_checker.sv
// Purpose: port assertions for the sleep/wake controller
// Assumes: one clock domain, arst_n releases all flags
// Notes:   running means out of hold with the core clock on
`include "sleep_wake_cfg.svh"
`default_nettype none
module sleep_wake_checker #(
	parameter logic [`HOLD_W-1:0] HOLD_POR  = '0,
	parameter logic [`HOLD_W-1:0] HOLD_SUB  = '0,
	parameter logic [`WDT_W-1:0]  WDT_LIMIT = '0
) (
	input wire logic       sys_clk,
	input wire logic       arst_n,
	input wire logic       ext_reset_n,
	input wire logic       reset_pin_is_ext_reset_n,
	input wire logic       wake_on_change_en,
	input wire logic       halt_op,
	input wire logic       core_reset,
	input wire logic       core_clk_en,
	input wire logic       osc_drive_en,
	input wire logic       timeout_flag_n,
	input wire logic       powerdown_flag_n,
	input wire logic       pin_wake_flag,
	input wire logic       prog_mode,
	input wire logic [5:0] pin_drive_out,
	input wire logic [5:0] pin_oe_out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic run;
	assign run = !core_reset && core_clk_en;
	a_halt_flags: assert property (
		run && halt_op |=> !powerdown_flag_n && timeout_flag_n)
		else $error("halt did not set the sleep flags");
	a_halt_osc_off: assert property (
		run && halt_op |=> !osc_drive_en && !core_clk_en)
		else $error("oscillator still on in sleep");
	a_wake_flag_mix: assert property (
		$rose(pin_wake_flag) |-> timeout_flag_n && !powerdown_flag_n)
		else $error("pin wake flags wrong");
	a_wake_full_reset: assert property (
		$rose(pin_wake_flag) |=> core_reset)
		else $error("pin wake without reset");
	a_wake_enabled: assert property (
		$rose(pin_wake_flag) |-> wake_on_change_en)
		else $error("pin wake while disabled");
	a_tmo_clears: assert property (
		$fell(timeout_flag_n) |-> !pin_wake_flag && $stable(powerdown_flag_n))
		else $error("timeout flags wrong");
	a_pd_por_only: assert property (
		!$rose(powerdown_flag_n))
		else $error("power-down flag set outside power-up");
	a_pins_frozen: assert property (
		!core_reset && !core_clk_en && $past(!core_clk_en) && !prog_mode
		|-> $stable(pin_drive_out) && $stable(pin_oe_out))
		else $error("pin state moved in sleep");
	a_hold_time: assert property (
		$rose(core_reset) |-> core_reset [*8])
		else $error("core hold too short");
	a_ext_wakes: assert property (
		reset_pin_is_ext_reset_n && $fell(ext_reset_n) && !prog_mode
		|-> ##[1:6] core_reset)
		else $error("external reset ignored");
	c_pin_wake: cover property ($rose(pin_wake_flag));
	c_wdt_wake: cover property ($fell(timeout_flag_n) && !powerdown_flag_n);
	c_prog: cover property ($rose(prog_mode));
endmodule
bind sleep_wake sleep_wake_checker #(.HOLD_POR(HOLD_POR),
	.HOLD_SUB(HOLD_SUB), .WDT_LIMIT(WDT_LIMIT)) chk_u (.sys_clk, .arst_n,
	.ext_reset_n, .reset_pin_is_ext_reset_n, .wake_on_change_en, .halt_op,
	.core_reset, .core_clk_en, .osc_drive_en, .timeout_flag_n,
	.powerdown_flag_n, .pin_wake_flag, .prog_mode, .pin_drive_out,
	.pin_oe_out);
`default_nettype wire

//--- test/pin_partner.sv
// Purpose: reset pin, wake pins and serial programmer facing the device
// Assumes: called from the bench at the falling edge of sys_clk
// Notes:   phase h (pin1 high h, low 2h cycles per bit) sets a prompt or slow programmer
`default_nettype none
module pin_partner (
	input  wire logic sys_clk,
	input  wire logic sdata_out,
	input  wire logic sdata_oe,
	output var  logic ext_reset_n,
	output var  logic vpp_high,
	output logic      pin0,
	output var  logic pin1,
	output var  logic pin3,
	output var  logic pin4
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv0;
	logic rel0;
	initial begin
		ext_reset_n = 1'b1;
		vpp_high = 1'b0;
		pin1 = 1'b0;
		pin3 = 1'b0;
		pin4 = 1'b0;
		drv0 = 1'b0;
		rel0 = 1'b0;
	end
	// a released line has no pull: show the inverse, never a stale level
	assign pin0 = sdata_oe ? sdata_out : (rel0 ? ~drv0 : drv0);
	task automatic pulse_reset(input int n);
		ext_reset_n = 1'b0;
		repeat (n) @(negedge sys_clk);
		ext_reset_n = 1'b1;
	endtask
	task automatic flip(input int idx);
		case (idx)
			0: drv0 = ~drv0;
			1: pin1 = ~pin1;
			3: pin3 = ~pin3;
			default: pin4 = ~pin4;
		endcase
	endtask
	task automatic enter_prog();
		drv0 = 1'b0;
		rel0 = 1'b0;
		pin1 = 1'b0;
		@(negedge sys_clk);
		vpp_high = 1'b1;
	endtask
	task automatic bitx(input logic b, input logic rel, input int h,
		output logic r);
		drv0 = b;
		rel0 = rel;
		repeat (h) @(negedge sys_clk);
		pin1 = 1'b1;
		repeat (h) @(negedge sys_clk);
		pin1 = 1'b0;
		repeat (h) @(negedge sys_clk);
		r = pin0;
	endtask
endmodule
`default_nettype wire

//--- test/sleep_wake_tb.sv
// Purpose: self-checking bench for the sleep/wake controller
// Assumes: hold counts 20 and 30 cycles, watchdog limit 50 cycles
// Notes:   flag model kept as integers, updated per wake event
`include "sleep_wake_cfg.svh"
`default_nettype none
module sleep_wake_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk, arst_n, ext_reset_n, vpp_high, p0, p1, p3, p4;
	logic        halt_op, wdt_clear_op, port_op, wdt_enable, code_protect;
	logic        reset_pin_is_ext_reset_n, wake_on_change_en, slow_osc_cfg;
	logic        core_reset, core_clk_en, osc_drive_en, prog_mode, mem_we;
	logic        timeout_flag_n, powerdown_flag_n, pin_wake_flag;
	logic        sdata_out, sdata_oe;
	logic [5:0]  pin_drive_in, pin_oe_in, pin_drive_out, pin_oe_out, exp_drv;
	logic [5:0]  exp_oe;
	logic [9:0]  mem_addr;
	logic [13:0] mem_rdata, mem_wdata, w;
	int          err_count, checks, cyc, m_wake, m_to, m_pd, h, we_n;
	int          pins[4] = '{0, 1, 3, 4};
	assign mem_rdata = {4'h9, mem_addr} ^ 14'h0a5c;
	sleep_wake #(.HOLD_POR(21'h14), .HOLD_SUB(21'h1e),
		.WDT_LIMIT(16'h0032)) dut_u (.sys_clk, .arst_n, .ext_reset_n,
		.vpp_high, .port_pin0(p0), .port_pin1(p1), .port_pin3(p3),
		.port_pin4(p4), .halt_op, .wdt_clear_op, .port_op, .wdt_enable,
		.reset_pin_is_ext_reset_n, .wake_on_change_en, .slow_osc_cfg, .code_protect,
		.pin_drive_in, .pin_oe_in, .mem_rdata, .core_reset, .core_clk_en,
		.osc_drive_en, .timeout_flag_n, .powerdown_flag_n, .pin_wake_flag,
		.prog_mode, .pin_drive_out, .pin_oe_out, .mem_addr, .mem_wdata,
		.mem_we, .sdata_out, .sdata_oe);
	pin_partner pu (.sys_clk, .sdata_out, .sdata_oe, .ext_reset_n,
		.vpp_high, .pin0(p0), .pin1(p1), .pin3(p3), .pin4(p4));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (mem_we === 1'b1)
			we_n++;
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk_val(input logic [13:0] got, input logic [13:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t value got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_flags();
		logic [2:0] e;
		e = {m_wake[0], m_to[0], m_pd[0]};
		checks++;
		if ({pin_wake_flag, timeout_flag_n, powerdown_flag_n} !== e) begin
			err_count++;
			$display("[FAIL] %0t flags got %h exp %h", $time,
				{pin_wake_flag, timeout_flag_n, powerdown_flag_n}, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// wake is seen only once the hold ends, so poll under a ceiling
	task automatic wait_run();
		int n;
		n = 0;
		tick(6);
		while (!(core_reset === 1'b0 && core_clk_en === 1'b1) && n < 400) begin
			tick(1);
			n++;
		end
		chk_val(14'(n < 400), 14'h1);
	endtask
	task automatic asleep();
		chk_val(14'({core_reset, core_clk_en}), 14'h0);
	endtask
	task automatic do_halt();
		halt_op = 1'b1;
		tick(1);
		halt_op = 1'b0;
		m_pd = 0;
		m_to = 1;
		tick(2);
		chk_val(14'(osc_drive_en), 14'h0);
	endtask
	task automatic send_cmd(input logic [5:0] c);
		logic r;
		for (int i = 0; i < 6; i++)
			pu.bitx(c[i], 1'b0, h, r);
	endtask
	task automatic word(input logic [13:0] d, input logic rel,
		output logic [13:0] q);
		logic r;
		for (int i = 0; i < 14; i++)
			pu.bitx(d[i], rel, h, q[i]);
		// a read holds the line until one more clock hands it back
		if (rel)
			pu.bitx(1'b0, 1'b1, h, r);
	endtask
	initial begin
		{arst_n, halt_op, wdt_clear_op, port_op, wdt_enable} = '0;
		{code_protect, wake_on_change_en, slow_osc_cfg} = '0;
		reset_pin_is_ext_reset_n = 1'b1;
		{pin_drive_in, pin_oe_in} = '0;
		void'($urandom(32'h2fdb));
		h = 3 + int'($urandom % 4);
		slow_osc_cfg = 1'($urandom);
		tick(2);
		arst_n = 1'b1;
		{m_wake, m_to, m_pd} = {32'd0, 32'd1, 32'd1};
		wait_run();
		chk_flags();
		$display("test power_up done");
		for (int i = 0; i < 4; i++) begin
			pin_drive_in = 6'($urandom);
			pin_oe_in = 6'($urandom);
			wake_on_change_en = 1'b0;
			port_op = 1'b1;
			tick(1);
			port_op = 1'b0;
			tick(2);
			exp_drv = pin_drive_in;
			exp_oe = pin_oe_in;
			do_halt();
			pin_drive_in = ~exp_drv;
			pin_oe_in = ~exp_oe;
			pu.flip(pins[i]);
			tick(12);
			asleep();
			pu.flip(pins[i]);
			tick(6);
			wake_on_change_en = 1'b1;
			tick(12);
			asleep();
			chk_val(14'(pin_drive_out), 14'(exp_drv));
			chk_val(14'(pin_oe_out), 14'(exp_oe));
			pu.flip(pins[i]);
			m_wake = 1;
			wait_run();
			chk_flags();
		end
		$display("test pin_wake done");
		// re-arm the change detector, else the next sleep wakes at once
		port_op = 1'b1;
		tick(1);
		port_op = 1'b0;
		pu.pulse_reset(4);
		m_wake = 0;
		wait_run();
		chk_flags();
		reset_pin_is_ext_reset_n = 1'b0;
		do_halt();
		pu.pulse_reset(4);
		tick(12);
		asleep();
		reset_pin_is_ext_reset_n = 1'b1;
		pu.pulse_reset(4);
		wait_run();
		chk_flags();
		$display("test ext_reset done");
		wdt_enable = 1'b1;
		repeat (3) begin
			wdt_clear_op = 1'b1;
			tick(1);
			wdt_clear_op = 1'b0;
			tick(40);
			chk_val(14'(core_reset), 14'h0);
		end
		tick(18);
		m_to = 0;
		wait_run();
		chk_flags();
		do_halt();
		tick(35);
		asleep();
		tick(25);
		m_to = 0;
		wait_run();
		chk_flags();
		wdt_clear_op = 1'b1;
		tick(1);
		wdt_clear_op = 1'b0;
		do_halt();
		tick(35);
		pu.flip(4);
		wait_run();
		tick(10);
		chk_val(14'(core_reset), 14'h0);
		wdt_enable = 1'b0;
		$display("test watchdog done");
		code_protect = 1'b1;
		pu.enter_prog();
		tick(6);
		chk_val(14'(prog_mode), 14'h1);
		send_cmd(`CMD_READ);
		word(14'h0, 1'b1, w);
		chk_val(w, {4'h9, 10'h000} ^ 14'h0a5c);
		repeat (64) send_cmd(`CMD_INC);
		chk_val(14'(mem_addr), 14'h0040);
		send_cmd(`CMD_READ);
		word(14'h0, 1'b1, w);
		chk_val(w, 14'h0);
		code_protect = 1'b0;
		send_cmd(`CMD_READ);
		word(14'h0, 1'b1, w);
		chk_val(w, {4'h9, 10'h040} ^ 14'h0a5c);
		send_cmd(`CMD_LOAD);
		word(14'h2a3c, 1'b0, w);
		tick(4);
		chk_val(mem_wdata, 14'h2a3c);
		chk_val(14'(we_n), 14'h1);
		send_cmd(`CMD_LOAD_ID);
		word(14'h3ff5, 1'b0, w);
		send_cmd(`CMD_READ);
		word(14'h0, 1'b1, w);
		chk_val(w, 14'h0005);
		send_cmd(`CMD_LOAD);
		word(14'h2a3c, 1'b0, w);
		send_cmd(`CMD_READ);
		word(14'h0, 1'b1, w);
		chk_val(w, 14'h000c);
		chk_val(14'(we_n), 14'h1);
		$display("test program_mode done");
		end_sim();
	end
endmodule
`default_nettype wire
